// *** rtl/config_response_message_gen.sv ***
// Notes on behaviour
// - a protection write is answered 41h when accepted, 01h when refused.
// - a protection read is answered 42h or 02h, then the stored byte in write layout.
// - bit 7 reads 0; bit 6 set keeps the pull-up connected in standby, ignored in sleep.
// - bit 5 picks sleep (1) or standby (0) for chip enable low; sleep forces disconnect.
// - bit 4 enables the neutral simulator and is clear after start-up.
// - bit 3 clear keeps undervoltage lockout active, set disables it.
// - bit 2 clear enables transistor overcurrent detection, set disables it.
// - bits 1:0 pick the overcurrent threshold, 00 by default.
// - a current-limit write is answered 43h or 03h.
// - a current-limit read is answered 44h or 04h.
// - both current-limit replies carry the full 8-bit reference code.
module config_response_message_gen
   import cfg_reply_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_accept,
   output logic reply_valid,
   output logic [7:0] reply_byte0,
   output logic [7:0] reply_byte1,
   output logic pullup_disconnect,
   output logic sleep_select,
   output logic neutral_sim_en,
   output logic uvlo_en,
   output logic oc_detect_en,
   output logic [1:0] oc_threshold_sel,
   output logic [7:0] current_limit_code,
   input wire logic chip_enable_low
);
   typedef struct packed {
      logic [7:0] prot;
      logic [7:0] ilim;
      logic valid;
      logic [7:0] b0;
      logic [7:0] b1;
   } state_t;

   state_t st;
   state_t next_st;
   logic known;
   logic ack;

   // refused or unknown commands leave both registers as they are
   always_comb begin
      next_st = st;
      next_st.valid = 1'b0;
      known = (cmd_code == CMD_SET_PROT) || (cmd_code == CMD_GET_PROT) ||
              (cmd_code == CMD_SET_ILIM) || (cmd_code == CMD_GET_ILIM);
      ack = cmd_accept && known;
      if (cmd_valid && known) begin
         next_st.valid = 1'b1;
         next_st.b0 = (cmd_code & CODE_MASK) | (ack ? (8'h01 << ACK_BIT) : 8'h00);
         case (cmd_code)
            CMD_SET_PROT: begin
               if (ack) next_st.prot = cmd_data & PROT_WRITE_MASK;
               next_st.b1 = 8'h00;
            end
            CMD_GET_PROT: next_st.b1 = st.prot;
            CMD_SET_ILIM: begin
               if (ack) next_st.ilim = cmd_data;
               next_st.b1 = ack ? cmd_data : st.ilim;
            end
            CMD_GET_ILIM: next_st.b1 = st.ilim;
            default: next_st.b1 = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{prot: PROT_RESET, ilim: ILIM_RESET, valid: 1'b0, b0: 8'h00, b1: 8'h00};
      end else begin
         st <= next_st;
      end
   end

   assign reply_valid = st.valid;
   assign reply_byte0 = st.b0;
   assign reply_byte1 = st.b1;
   assign sleep_select = st.prot[PROT_SLEEP_BIT];
   assign pullup_disconnect = chip_enable_low &&
      (st.prot[PROT_SLEEP_BIT] || !st.prot[PROT_PULLUP_KEEP_BIT]);
   assign neutral_sim_en = st.prot[PROT_NEUTRAL_BIT];
   assign uvlo_en = !st.prot[PROT_UVLO_OFF_BIT];
   assign oc_detect_en = !st.prot[PROT_OC_OFF_BIT];
   assign oc_threshold_sel = st.prot[PROT_OC_LVL_MSB:0];
   assign current_limit_code = st.ilim;

   a_prot_set_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_SET_PROT |=> reply_valid &&
      reply_byte0 == ($past(cmd_accept) ? 8'h41 : 8'h01))
      else $error("bad protection write reply");
   a_prot_wr_byte1: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_SET_PROT |=> reply_byte1 == 8'h00)
      else $error("protection write reply byte not zero");
   a_refuse_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && !cmd_accept |=> $stable(st.prot) && $stable(st.ilim))
      else $error("refused command changed a register");

   a_prot_get_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_GET_PROT |=> reply_byte1 == $past(st.prot) &&
      reply_byte0 == ($past(cmd_accept) ? 8'h42 : 8'h02))
      else $error("bad protection read reply");

   a_prot_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      !st.prot[PROT_RSVD_BIT]) else $error("reserved bit set");
   a_pullup_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      chip_enable_low && !sleep_select && st.prot[PROT_PULLUP_KEEP_BIT] |->
      !pullup_disconnect)
      else $error("pull-up dropped in standby");
   a_pullup_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
      chip_enable_low && !st.prot[PROT_PULLUP_KEEP_BIT] |-> pullup_disconnect)
      else $error("pull-up not disconnected");
   a_pullup_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !chip_enable_low |-> !pullup_disconnect)
      else $error("pull-up disconnected while enabled");

   a_sleep_disc: assert property (@(posedge core_clk) disable iff (!rst_n)
      chip_enable_low && sleep_select |-> pullup_disconnect)
      else $error("sleep without disconnect");
   a_sleep_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_PROT |=>
      sleep_select == $past(cmd_data[PROT_SLEEP_BIT]))
      else $error("sleep select not written");

   a_neutral_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_PROT |=>
      neutral_sim_en == $past(cmd_data[PROT_NEUTRAL_BIT]))
      else $error("neutral enable not written");

   a_uvlo_pol: assert property (@(posedge core_clk) disable iff (!rst_n)
      uvlo_en != st.prot[PROT_UVLO_OFF_BIT]) else $error("lockout polarity");
   a_uvlo_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_PROT |=>
      uvlo_en == !$past(cmd_data[PROT_UVLO_OFF_BIT]))
      else $error("lockout bit not written");

   a_oc_pol: assert property (@(posedge core_clk) disable iff (!rst_n)
      oc_detect_en != st.prot[PROT_OC_OFF_BIT]) else $error("detect polarity");
   a_oc_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_PROT |=>
      oc_detect_en == !$past(cmd_data[PROT_OC_OFF_BIT]))
      else $error("detect bit not written");

   a_thresh_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_PROT |=>
      oc_threshold_sel == $past(cmd_data[PROT_OC_LVL_MSB:0]))
      else $error("threshold not written");

   a_ilim_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_SET_ILIM |=>
      reply_byte0 == ($past(cmd_accept) ? 8'h43 : 8'h03))
      else $error("bad limit write reply");
   a_ilim_nak_old: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && !cmd_accept && cmd_code == CMD_SET_ILIM |=>
      reply_byte1 == $past(current_limit_code) &&
      current_limit_code == $past(current_limit_code))
      else $error("refused limit write changed the code");

   a_ilim_get: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_code == CMD_GET_ILIM |=> reply_byte1 == current_limit_code &&
      reply_byte0 == ($past(cmd_accept) ? 8'h44 : 8'h04))
      else $error("bad limit read reply");

   a_ilim_round: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_ILIM ##1
      cmd_valid && cmd_code == CMD_GET_ILIM |=> reply_byte1 == $past(cmd_data, 2))
      else $error("limit code lost");
   a_ilim_wr_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_ILIM |=>
      reply_byte1 == $past(cmd_data) && current_limit_code == $past(cmd_data))
      else $error("limit write reply lost the code");

   a_reply_known: assert property (@(posedge core_clk) disable iff (!rst_n)
      reply_valid |-> reply_byte0[7] == 1'b0) else $error("reply bit 7 set");
   a_unknown_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid && !known |=> !reply_valid) else $error("reply to unknown command");
   a_reply_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
      reply_valid |-> $past(cmd_valid && known)) else $error("reply without command");

   c_prot_write: cover property (@(posedge core_clk)
      cmd_valid && cmd_accept && cmd_code == CMD_SET_PROT);
   c_refused: cover property (@(posedge core_clk) cmd_valid && !cmd_accept && known);
   c_ilim_round: cover property (@(posedge core_clk)
      cmd_valid && cmd_code == CMD_SET_ILIM ##1 cmd_valid && cmd_code == CMD_GET_ILIM);
   c_ilim_refused: cover property (@(posedge core_clk)
      cmd_valid && !cmd_accept && cmd_code == CMD_SET_ILIM);
   c_sleep_disc: cover property (@(posedge core_clk)
      chip_enable_low && sleep_select && st.prot[PROT_PULLUP_KEEP_BIT]);
endmodule : config_response_message_gen

// *** pkg/cfg_reply_pkg.sv ***
package cfg_reply_pkg;
   // command codes received from the host
   localparam logic [7:0] CMD_SET_PROT = 8'h81;
   localparam logic [7:0] CMD_GET_PROT = 8'h82;
   localparam logic [7:0] CMD_SET_ILIM = 8'h83;
   localparam logic [7:0] CMD_GET_ILIM = 8'h84;
   // reply first-byte formation
   localparam int ACK_BIT = 6;
   localparam logic [7:0] CODE_MASK = 8'h3f;
   // protection/power configuration fields
   localparam int PROT_RSVD_BIT = 7;
   localparam int PROT_PULLUP_KEEP_BIT = 6;
   localparam int PROT_SLEEP_BIT = 5;
   localparam int PROT_NEUTRAL_BIT = 4;
   localparam int PROT_UVLO_OFF_BIT = 3;
   localparam int PROT_OC_OFF_BIT = 2;
   localparam int PROT_OC_LVL_MSB = 1;
   localparam logic [7:0] PROT_WRITE_MASK = 8'h7f;
   localparam logic [7:0] PROT_RESET = 8'h00;
   localparam logic [7:0] ILIM_RESET = 8'h40;
endpackage : cfg_reply_pkg

// *** tb/host_model.sv ***
module host_model (
   input wire logic core_clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_data,
   output logic cmd_accept,
   output logic chip_enable_low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_data = 8'h00;
      cmd_accept = 1'b0;
      chip_enable_low = 1'b0;
   end
   task send(input logic [7:0] c, input logic [7:0] d, input logic a, input logic e);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      cmd_accept <= a;
      chip_enable_low <= e;
      @(posedge core_clk);
   endtask : send
   // released lines flip so stale bytes never look valid
   task idle();
      cmd_valid <= 1'b0;
      cmd_code <= ~cmd_code;
      cmd_data <= ~cmd_data;
      @(posedge core_clk);
   endtask : idle
endmodule : host_model

// *** tb/testbench.sv ***
module testbench;
   import cfg_reply_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid, cmd_accept, chip_enable_low, reply_valid, pullup_disconnect;
   logic sleep_select, neutral_sim_en, uvlo_en, oc_detect_en;
   logic [7:0] cmd_code, cmd_data, reply_byte0, reply_byte1, current_limit_code;
   logic [1:0] oc_threshold_sel;
   logic [7:0] prot = 8'h00;
   logic [7:0] lim = 8'h40;
   logic [31:0] q[$];
   logic [31:0] n;
   int err_count = 0;
   int checks = 0;
   always #5 core_clk = ~core_clk;
   host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .cmd_accept(cmd_accept), .chip_enable_low(chip_enable_low));
   config_response_message_gen dut (.core_clk(core_clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .cmd_accept(cmd_accept), .reply_valid(reply_valid), .reply_byte0(reply_byte0),
      .reply_byte1(reply_byte1), .pullup_disconnect(pullup_disconnect),
      .sleep_select(sleep_select), .neutral_sim_en(neutral_sim_en), .uvlo_en(uvlo_en),
      .oc_detect_en(oc_detect_en), .oc_threshold_sel(oc_threshold_sel),
      .current_limit_code(current_limit_code), .chip_enable_low(chip_enable_low));
   task bad(input string m);
      err_count++;
      $display("BAD %0t %s", $time, m);
   endtask : bad
   task cmd(input logic [7:0] c, input logic [7:0] d, input logic a, input logic e);
      logic [7:0] b1;
      b1 = lim;
      case (c)
         CMD_SET_PROT: begin
            b1 = 8'h00;
            if (a) prot = d & 8'h7f;
         end
         CMD_GET_PROT: b1 = prot;
         CMD_SET_ILIM: if (a) begin
            lim = d;
            b1 = d;
         end
         default: ;
      endcase
      if (c inside {[8'h81:8'h84]}) q.push_back({1'b0, a, c[5:0], b1, prot, lim});
      host.send(c, d, a, e);
   endtask : cmd
   task drain();
      host.idle();
      for (int i = 0; i < 4 && q.size() != 0; i++) @(posedge core_clk);
      if (q.size() != 0) bad("missing reply");
   endtask : drain
   // outputs are looked at half a cycle after the edge that launches them
   always @(negedge core_clk) begin
      if (reply_valid === 1'b1 && q.size() == 0) bad("unexpected reply");
      else if (reply_valid === 1'b1) begin
         n = q.pop_front();
         checks += 8;
         if ({reply_byte0, reply_byte1} !== n[31:16])
            bad("reply bytes");
         if (neutral_sim_en !== n[12]) bad("neutral field");
         if (uvlo_en !== ~n[11]) bad("lockout field");
         if (oc_detect_en !== ~n[10]) bad("detect field");
         if (oc_threshold_sel !== n[9:8]) bad("threshold field");
         if (sleep_select !== n[13]) bad("sleep field");
         if (pullup_disconnect !== (chip_enable_low & (n[13] | ~n[14])))
            bad("pull-up");
         if (current_limit_code !== n[7:0]) bad("limit code");
      end
   end
   task test_done();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   initial begin
      void'($urandom(18));
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      cmd(CMD_GET_PROT, 8'h00, 1'b1, 1'b1);
      cmd(CMD_GET_ILIM, 8'h00, 1'b1, 1'b0);
      $display("test defaults done");
      for (int i = 0; i < 8; i++) cmd(8'h81 + 8'(i / 2), 8'hd5 ^ 8'(i), i[0], i[1]);
      cmd(8'h85, 8'h12, 1'b1, 1'b0);
      $display("test codes done");
      for (int i = 0; i < 300; i++)
         cmd(8'h80 + 8'($urandom % 6), 8'($urandom), 1'($urandom), 1'($urandom));
      $display("test random done");
      drain();
      // a second reset in mid-run must bring both registers back to defaults
      rst_n <= 1'b0;
      prot = PROT_RESET;
      lim = ILIM_RESET;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      cmd(CMD_GET_PROT, 8'h00, 1'b1, 1'b0);
      cmd(CMD_GET_ILIM, 8'h00, 1'b0, 1'b1);
      drain();
      $display("test reset done");
      test_done();
   end
endmodule : testbench
